// >>> inc/crs_pkg.sv
// Constants and types of the reset sequencer and static clock tracker
// Operation
// - Reset forces selects low, data floats; grant follows request
// - Grant low in reset only without request
// - About 50 system clocks before first fetch
// - Synchronous reset ends cycle at second fall
// - Async assertion leaves next phase undefined; the code realigns phase to CRS_PHASE_RST when the cycle ends
// - State is static, any clock down to DC
// - Clock may stop in either phase
// - Single step by supplied clock edges only
package crs_pkg;
  localparam int CRS_DATA_W = 16;
  localparam int CRS_CNT_W = 8;
  localparam int CRS_INIT_CYCLES = 50;
  localparam int CRS_TERM_FALLS = 2;
  localparam int CRS_RESET_MIN_CYCLES = 16;
  localparam logic CRS_SYNC_RST_VAL = 1'b1;
  localparam logic CRS_PHASE_RST = 1'b0;
  localparam logic [CRS_DATA_W-1:0] CRS_DATA_RST = 16'h0000;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b000,
    ST_TERM  = 3'b001,
    ST_HELD  = 3'b010,
    ST_INIT  = 3'b011,
    ST_FETCH = 3'b100
  } crs_state_e;
endpackage

// >>> src/crs_reset_seq.sv
// Reset sequencer with static, stoppable processor clock tracking
`timescale 1ns/1ps
module crs_reset_seq #(
  parameter int INIT_CYCLES = crs_pkg::CRS_INIT_CYCLES,
  parameter int TERM_FALLS = crs_pkg::CRS_TERM_FALLS
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_cpu_reset,
  input wire logic i_sys_clk,
  input wire logic i_bus_req,
  input wire logic i_wr_en,
  input wire logic [crs_pkg::CRS_DATA_W-1:0] i_wr_data,
  output logic o_mem_io_sel,
  output logic o_code_or_irq_ack_select,
  output logic o_bus_grant_ack,
  output logic [crs_pkg::CRS_DATA_W-1:0] o_data_bus_lines_out,
  output logic o_data_bus_lines_oe,
  output logic o_proc_phase,
  output logic o_cycle_active,
  output logic o_init_busy,
  output logic o_fetch_start
);
  import crs_pkg::*;

  // Counts must fit the counter and leave room for the compare
  if (INIT_CYCLES < 2 || INIT_CYCLES > 255) begin : g_bad_init
    $error("INIT_CYCLES out of range");
  end
  if (TERM_FALLS < 1 || TERM_FALLS > 255) begin : g_bad_term
    $error("TERM_FALLS out of range");
  end

  localparam logic [CRS_CNT_W-1:0] INIT_LAST = CRS_CNT_W'(INIT_CYCLES - 1);
  localparam logic [CRS_CNT_W-1:0] TERM_LAST = CRS_CNT_W'(TERM_FALLS - 1);

  crs_state_e state_q, state_d;
  logic rst_s;
  logic sclk_q;
  logic [CRS_CNT_W-1:0] cnt_q, cnt_d;
  logic phase_d, active_d, mem_io_d, code_d, grant_d, oe_d, busy_d, fetch_d;
  logic [CRS_DATA_W-1:0] dout_d;

  crs_sync #(
    .RESET_VAL(CRS_SYNC_RST_VAL)
  ) crs_sync_inst (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_d(i_cpu_reset),
    .o_q(rst_s)
  );

  // counts advance only on system clock falls
  wire sys_fall = sclk_q & ~i_sys_clk;
  wire cnt_init_done = sys_fall && (cnt_q == INIT_LAST);
  wire cnt_term_done = sys_fall && (cnt_q == TERM_LAST);
  wire in_reset_d = (state_d == ST_HELD);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      ST_RUN: begin
        if (rst_s) begin
          state_d = ST_TERM;
          cnt_d = '0;
        end
      end
      // count falls until the current cycle ends
      ST_TERM: begin
        if (cnt_term_done) begin
          state_d = ST_HELD;
          cnt_d = '0;
        end else if (sys_fall) begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      // release taken as synchronous to the system clock
      ST_HELD: begin
        if (!rst_s) begin
          state_d = ST_INIT;
          cnt_d = '0;
        end
      end
      ST_INIT: begin
        if (rst_s) begin
          state_d = ST_HELD;
          cnt_d = '0;
        end else if (cnt_init_done) begin
          state_d = ST_FETCH;
          cnt_d = '0;
        end else if (sys_fall) begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      ST_FETCH: begin
        state_d = rst_s ? ST_TERM : ST_RUN;
      end
      default: begin
        state_d = ST_HELD;
        cnt_d = '0;
      end
    endcase
  end

  // phase toggles on falls and holds while the clock stops
  // phase realigned to a known value when the cycle ends
  assign phase_d = (state_q == ST_TERM && cnt_term_done) ? CRS_PHASE_RST :
                   (sys_fall ? ~o_proc_phase : o_proc_phase);
  assign active_d = (state_d == ST_FETCH) ? 1'b1 :
                    ((state_d == ST_HELD || state_d == ST_INIT) ? 1'b0 : o_cycle_active);
  assign mem_io_d = in_reset_d ? 1'b0 : (o_mem_io_sel | (state_d == ST_FETCH));
  assign code_d = in_reset_d ? 1'b0 : (o_code_or_irq_ack_select | (state_d == ST_FETCH));
  // grant follows request, low in reset without one
  assign grant_d = i_bus_req;
  assign oe_d = in_reset_d ? 1'b0 : i_wr_en;
  assign dout_d = in_reset_d ? CRS_DATA_RST : i_wr_data;
  assign busy_d = (state_d == ST_INIT);
  assign fetch_d = (state_d == ST_FETCH);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_HELD;
      cnt_q <= '0;
      sclk_q <= 1'b0;
      o_proc_phase <= CRS_PHASE_RST;
      o_cycle_active <= 1'b0;
      o_mem_io_sel <= 1'b0;
      o_code_or_irq_ack_select <= 1'b0;
      o_bus_grant_ack <= 1'b0;
      o_data_bus_lines_oe <= 1'b0;
      o_data_bus_lines_out <= CRS_DATA_RST;
      o_init_busy <= 1'b0;
      o_fetch_start <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sclk_q <= i_sys_clk;
      o_proc_phase <= phase_d;
      o_cycle_active <= active_d;
      o_mem_io_sel <= mem_io_d;
      o_code_or_irq_ack_select <= code_d;
      o_bus_grant_ack <= grant_d;
      o_data_bus_lines_oe <= oe_d;
      o_data_bus_lines_out <= dout_d;
      o_init_busy <= busy_d;
      o_fetch_start <= fetch_d;
    end
  end

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  chk_reset_pin_state: assert property (
    state_q == ST_HELD |-> !o_mem_io_sel && !o_code_or_irq_ack_select && !o_data_bus_lines_oe)
    else $error("pins not in reset state");

  chk_grant_no_req: assert property (
    state_q == ST_HELD && !$past(i_bus_req) |-> !o_bus_grant_ack)
    else $error("grant high in reset without request");

  chk_init_to_fetch: assert property (
    state_q == ST_INIT && !rst_s && sys_fall && cnt_q == INIT_LAST
    |=> state_q == ST_FETCH ##1 state_q != ST_FETCH)
    else $error("fetch not started after init count");

  chk_fetch_after_init: assert property (
    $rose(o_fetch_start) |-> $past(cnt_q, 2) == INIT_LAST)
    else $error("fetch started early");

  chk_term_second_fall: assert property (
    state_q == ST_TERM && sys_fall && cnt_q == TERM_LAST
    |=> state_q == ST_HELD ##1 !o_cycle_active && o_proc_phase == CRS_PHASE_RST)
    else $error("cycle not ended at second fall");

  chk_enter_term: assert property (
    state_q == ST_RUN && rst_s |=> state_q == ST_TERM && cnt_q == '0)
    else $error("reset not seen in run");

  chk_init_static: assert property (
    state_q == ST_INIT && !sys_fall && !rst_s |=> $stable(cnt_q))
    else $error("init count moved without clock edge");

  chk_phase_static: assert property (
    !sys_fall |=> o_proc_phase == $past(o_proc_phase))
    else $error("phase moved with clock stopped");

  chk_fetch_pulse: assert property (
    o_fetch_start |=> !o_fetch_start)
    else $error("fetch pulse too long");
endmodule

// >>> src/crs_sync.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
module crs_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_d,
  output logic o_q
);
  logic meta_q;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= RESET_VAL;
      o_q <= RESET_VAL;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end
endmodule

// >>> tb/crs_sys_src.sv
// System clock generator and device reset source model
`timescale 1ns/1ps
module crs_sys_src (
  input wire logic i_core_clk,
  input wire logic i_run,
  input wire logic i_rst_req,
  output logic o_sys_clk,
  output logic o_cpu_reset
);
  logic [1:0] div_q = 2'h0;
  logic sclk_q = 1'b0;
  logic rst_pin_q = 1'b1;
  assign o_sys_clk = sclk_q;
  assign o_cpu_reset = rst_pin_q;
  // reset edges only at a clock fall
  always @(posedge i_core_clk) begin
    if (i_run && div_q == 2'h2) begin
      sclk_q <= ~sclk_q;
      if (sclk_q) rst_pin_q <= i_rst_req;
    end
    if (i_run) div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
  end
endmodule

// >>> tb/test_cpu_reset_and_static_clock.sv
// Testbench of the reset sequencer and static clock tracker
`timescale 1ns/1ps
module test_cpu_reset_and_static_clock;
  import crs_pkg::*;
  localparam int INIT_N = 4;
  logic clk = 1'b0, rst = 1'b1, run = 1'b1, rreq = 1'b1, breq = 1'b0, wen = 1'b0;
  logic [15:0] wdat = 16'h0000;
  logic sclk, crst, sel, cod, gnt, oe, ph, act, busy, fst, ps = 1'b0;
  logic [15:0] dout;
  int n_mismatch = 0, total_checks = 0, falls = 0, f0, k;
  crs_reset_seq #(.INIT_CYCLES(INIT_N)) crs_reset_seq_inst (.i_core_clk(clk), .i_rst(rst),
    .i_cpu_reset(crst), .i_sys_clk(sclk), .i_bus_req(breq), .i_wr_en(wen),
    .i_wr_data(wdat), .o_mem_io_sel(sel), .o_code_or_irq_ack_select(cod),
    .o_bus_grant_ack(gnt), .o_data_bus_lines_out(dout), .o_data_bus_lines_oe(oe),
    .o_proc_phase(ph), .o_cycle_active(act), .o_init_busy(busy), .o_fetch_start(fst));
  crs_sys_src crs_sys_src_inst (.i_core_clk(clk), .i_run(run), .i_rst_req(rreq),
    .o_sys_clk(sclk), .o_cpu_reset(crst));
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    ps <= sclk;
    if (ps && !sclk) falls <= falls + 1;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tmo(input bit ok);
    if (!ok) begin
      n_mismatch++;
      stop_test();
    end
  endtask
  // Waits for the reset pin to reach v, then notes the fall count
  task automatic mark(input logic v);
    for (k = 0; k < 200 && crst !== v; k++) @(posedge clk);
    tmo(crst === v);
    @(posedge clk);
    @(posedge clk);
    f0 = falls;
  endtask
  task automatic test_held();
    wen <= 1'b1;
    wdat <= 16'ha5c3;
    // reset held over 16 system clocks
    for (k = 0; k < 400 && falls < 20; k++) @(posedge clk);
    tmo(falls >= 20);
    check("sel", {15'h0, sel}, 16'h0000);
    check("cod", {15'h0, cod}, 16'h0000);
    check("oe", {15'h0, oe}, 16'h0000);
    check("data held", dout, CRS_DATA_RST);
    check("gnt", {15'h0, gnt}, 16'h0000);
    breq <= 1'b1;
    repeat (3) @(posedge clk);
    check("gnt req", {15'h0, gnt}, 16'h0001);
    breq <= 1'b0;
    $display("test held done");
  endtask
  task automatic test_init_stop();
    logic p;
    rreq <= 1'b0;
    mark(1'b0);
    for (k = 0; k < 200 && falls - f0 < 2; k++) @(posedge clk);
    tmo(falls - f0 >= 2);
    run <= 1'b0;
    repeat (4) @(posedge clk);
    p = ph;
    repeat (100) @(posedge clk);
    check("phase held", {15'h0, ph}, {15'h0, p});
    check("busy held", {15'h0, busy}, 16'h0001);
    check("fetch held", {15'h0, sel}, 16'h0000);
    run <= 1'b1;
    for (k = 0; k < 100 && falls - f0 < 3; k++) @(posedge clk);
    tmo(falls - f0 >= 3);
    check("phase step", {15'h0, ph}, {15'h0, ~p});
    for (k = 0; k < 400 && fst !== 1'b1; k++) @(posedge clk);
    tmo(fst === 1'b1);
    check("init falls", 16'(falls - f0), 16'(INIT_N));
    @(posedge clk);
    check("fetch pulse", {15'h0, fst}, 16'h0000);
    check("busy done", {15'h0, busy}, 16'h0000);
    check("act run", {15'h0, act}, 16'h0001);
    check("sel run", {15'h0, sel}, 16'h0001);
    check("cod run", {15'h0, cod}, 16'h0001);
    check("oe run", {15'h0, oe}, 16'h0001);
    check("data", dout, 16'ha5c3);
    $display("test init stop done");
  endtask
  task automatic test_reassert();
    rreq <= 1'b1;
    mark(1'b1);
    for (k = 0; k < 400 && sel !== 1'b0; k++) @(posedge clk);
    tmo(sel === 1'b0);
    check("term falls", 16'(falls - f0), 16'h0002);
    check("oe term", {15'h0, oe}, 16'h0000);
    check("act term", {15'h0, act}, 16'h0000);
    check("phase term", {15'h0, ph}, {15'h0, CRS_PHASE_RST});
    $display("test reassert done");
  endtask
  // Reset raised in mid-init must restart the whole count
  task automatic test_reinit();
    rreq <= 1'b0;
    mark(1'b0);
    for (k = 0; k < 200 && falls - f0 < 2; k++) @(posedge clk);
    tmo(falls - f0 >= 2);
    check("busy mid", {15'h0, busy}, 16'h0001);
    rreq <= 1'b1;
    mark(1'b1);
    // reset held over 16 system clocks
    for (k = 0; k < 400 && falls - f0 < 18; k++) @(posedge clk);
    tmo(falls - f0 >= 18);
    check("busy reinit", {15'h0, busy}, 16'h0000);
    check("sel reinit", {15'h0, sel}, 16'h0000);
    rreq <= 1'b0;
    mark(1'b0);
    for (k = 0; k < 400 && fst !== 1'b1; k++) @(posedge clk);
    tmo(fst === 1'b1);
    check("reinit falls", 16'(falls - f0), 16'(INIT_N));
    $display("test reinit done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    test_held();
    test_init_stop();
    test_reassert();
    test_reinit();
    stop_test();
  end
endmodule
